// File: hw/gev_event_blocks.v
// General event register blocks with lid and embedded controller event sources.
`timescale 1ns/1ps
`include "gev_regs.vh"

// Overview of operation
// - Two event blocks, each holding one flag register and one mask register.
// - Each block base sits on a 32-bit aligned I/O address.
// - Flag register fills first half of block, mask register second half.
// - Flag sets while event active, clears only by writing one.
// - Each flag bit pairs with the mask bit at the same position.
// - Interrupt asserts whenever any flag bit and its mask bit are set.
// - While sleeping, a newly set enabled flag raises a wake request.
// - Lid flag sets on press or release, chosen by the polarity bit.
// - Polarity high sets on lid high; polarity low sets on lid low.
// - Lid polarity at bit 0, lid flag at bit 1 of byte 0x200.
// - Lid flag feeds bank 0 flag bit 1 as a child event.
// - Top-level flags hold controller, ring and lid events.
// - Controller flag marks pending queries; query answers 34 for mains, 35 dock.
module gev_event_blocks #(
    parameter [15:0] BANK0_BASE = `GEV_BANK0_BASE,
    parameter [15:0] BANK1_BASE = `GEV_BANK1_BASE,
    parameter [15:0] BLOCK_LEN = `GEV_BLOCK_LEN
) (
    input wire clk_in,
    input wire arst_n_in,
    input wire [15:0] io_addr_in,
    input wire io_rd_in,
    input wire io_wr_in,
    input wire [7:0] io_wdata_in,
    output reg [7:0] io_rdata_out,
    output reg io_rvalid_out,
    input wire [7:0] bank0_event_in,
    input wire [7:0] bank1_event_in,
    input wire lid_in,
    input wire ring_n_in,
    input wire mains_detect_n_in,
    input wire dock_event_in,
    input wire sleeping_in,
    output reg system_control_interrupt_out,
    output reg wake_request_out
);

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    // Flags at the base, mask at base plus half the length; bases are
    // forced onto 32-bit boundaries so a bad parameter cannot misalign.
    localparam [15:0] B0_FLAGS = {BANK0_BASE[15:2], 2'b00};
    localparam [15:0] B0_MASK = B0_FLAGS + {1'b0, BLOCK_LEN[15:1]};
    localparam [15:0] B1_FLAGS = {BANK1_BASE[15:2], 2'b00};
    localparam [15:0] B1_MASK = B1_FLAGS + {1'b0, BLOCK_LEN[15:1]};
    localparam NSYNC = 21;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire [NSYNC-1:0] raw_pins;
    reg [NSYNC-1:0] sync1;
    reg [NSYNC-1:0] sync2;
    reg [NSYNC-1:0] sync3;
    reg [NSYNC-1:0] pins;

    assign raw_pins = {sleeping_in, ~ring_n_in, ~mains_detect_n_in, dock_event_in,
                       lid_in, bank1_event_in, bank0_event_in};

    // Three stages per pin; a change is accepted only once stages two and
    // three agree, which filters a single-cycle glitch at the cost of latency.
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                    pins[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= raw_pins[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi]) begin
                        pins[gi] <= sync3[gi];
                    end
                end
            end
        end
    endgenerate

    wire [7:0] b0_pin = pins[7:0];
    wire [7:0] b1_pin = pins[15:8];
    wire lid_level = pins[16];
    wire dock_level = pins[17];
    wire mains_level = pins[18];
    wire ring_level = pins[19];
    wire sleep_level = pins[20];

    // Count the edges until the synchronisers hold real pin levels; their
    // cleared state would otherwise read as a closed lid right after reset.
    reg [2:0] sync_warm;
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync_warm <= 3'h0;
        end else if (sync_warm != `GEV_SYNC_WARM) begin
            sync_warm <= sync_warm + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    reg [7:0] event_bank0_flags;
    reg [7:0] event_bank0_mask;
    reg [7:0] event_bank1_flags;
    reg [7:0] event_bank1_mask;
    reg lid_polarity_field;
    reg lid_event_field;
    reg mains_pending;
    reg dock_pending;
    reg mains_prev;
    reg dock_prev;

    // Write-one-to-clear byte for an address, zero otherwise.
    function [7:0] clear_byte;
        input [15:0] addr;
        begin
            clear_byte = (io_wr_in && io_addr_in == addr) ? io_wdata_in : 8'h00;
        end
    endfunction

    wire wr_lid = io_wr_in && (io_addr_in == `GEV_LID_CTRL_ADDR);
    wire rd_query = io_rd_in && (io_addr_in == `GEV_QUERY_ADDR);
    wire ec_event = mains_pending | dock_pending;
    // The lid is judged against the polarity being written, so one byte that
    // flips the polarity and clears the flag does not set it again at once.
    wire next_lid_polarity_select = wr_lid ? io_wdata_in[`GEV_LID_POLARITY_BIT] : lid_polarity_field;
    wire lid_hit = (sync_warm == `GEV_SYNC_WARM) && (lid_level == next_lid_polarity_select);

    // On-chip sources join the bank 0 pins at their fixed positions.
    reg [7:0] b0_active;
    always @* begin
        b0_active = b0_pin;
        b0_active[`GEV_EC_BIT] = b0_pin[`GEV_EC_BIT] | ec_event;
        b0_active[`GEV_LID_BIT] = b0_pin[`GEV_LID_BIT] | lid_event_field;
        b0_active[`GEV_RING_BIT] = b0_pin[`GEV_RING_BIT] | ring_level;
    end

    wire [7:0] next_b0_flags = (event_bank0_flags & ~clear_byte(B0_FLAGS)) | b0_active;
    wire [7:0] next_b1_flags = (event_bank1_flags & ~clear_byte(B1_FLAGS)) | b1_pin;

    // Flags: a live event wins over a same-cycle clear so nothing is lost.
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            event_bank0_flags <= `GEV_FLAGS_RESET;
            event_bank1_flags <= `GEV_FLAGS_RESET;
            event_bank0_mask <= `GEV_MASK_RESET;
            event_bank1_mask <= `GEV_MASK_RESET;
        end else begin
            event_bank0_flags <= next_b0_flags;
            event_bank1_flags <= next_b1_flags;
            if (io_wr_in && io_addr_in == B0_MASK) begin
                event_bank0_mask <= io_wdata_in;
            end
            if (io_wr_in && io_addr_in == B1_MASK) begin
                event_bank1_mask <= io_wdata_in;
            end
        end
    end

    // Lid control byte: polarity is plain read/write, the lid flag is
    // write-one-to-clear and sets while the lid sits at the selected level.
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lid_polarity_field <= `GEV_LID_POLARITY_RESET;
            lid_event_field <= 1'b0;
        end else begin
            if (wr_lid) begin
                lid_polarity_field <= io_wdata_in[`GEV_LID_POLARITY_BIT];
            end
            lid_event_field <= (lid_event_field &
                                ~(wr_lid & io_wdata_in[`GEV_LID_FLAG_BIT])) | lid_hit;
        end
    end

    // Query sources: an asserting edge on mains detect or dock marks a query pending;
    // a read of the query port answers mains before dock and retires that one.
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mains_pending <= 1'b0;
            dock_pending <= 1'b0;
            mains_prev <= 1'b0;
            dock_prev <= 1'b0;
        end else begin
            mains_prev <= mains_level;
            dock_prev <= dock_level;
            mains_pending <= (mains_pending & ~rd_query) | (mains_level & ~mains_prev);
            dock_pending <= (dock_pending & ~(rd_query & ~mains_pending)) |
                            (dock_level & ~dock_prev);
        end
    end

    // ------------------------------------------------------------
    // Read data, interrupt and wake
    // ------------------------------------------------------------
    reg [7:0] next_rdata;
    always @* begin
        if (io_addr_in == B0_FLAGS) begin
            next_rdata = event_bank0_flags;
        end else if (io_addr_in == B0_MASK) begin
            next_rdata = event_bank0_mask;
        end else if (io_addr_in == B1_FLAGS) begin
            next_rdata = event_bank1_flags;
        end else if (io_addr_in == B1_MASK) begin
            next_rdata = event_bank1_mask;
        end else if (io_addr_in == `GEV_LID_CTRL_ADDR) begin
            next_rdata = {6'h00, lid_event_field, lid_polarity_field};
        end else if (io_addr_in == `GEV_QUERY_ADDR) begin
            next_rdata = mains_pending ? `GEV_QUERY_AC :
                         (dock_pending ? `GEV_QUERY_DOCK : 8'h00);
        end else begin
            next_rdata = 8'h00;
        end
    end

    wire [7:0] b0_live = event_bank0_flags & event_bank0_mask;
    wire [7:0] b1_live = event_bank1_flags & event_bank1_mask;
    wire [7:0] b0_rise = next_b0_flags & ~event_bank0_flags & event_bank0_mask;
    wire [7:0] b1_rise = next_b1_flags & ~event_bank1_flags & event_bank1_mask;

    // Wake is held until the system leaves sleep, so the power sequencer
    // cannot miss a short request.
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            io_rdata_out <= 8'h00;
            io_rvalid_out <= 1'b0;
            system_control_interrupt_out <= 1'b0;
            wake_request_out <= 1'b0;
        end else begin
            io_rvalid_out <= io_rd_in;
            io_rdata_out <= io_rd_in ? next_rdata : 8'h00;
            system_control_interrupt_out <= |{b0_live, b1_live};
            wake_request_out <= sleep_level & (wake_request_out | (|{b0_rise, b1_rise}));
        end
    end

endmodule // gev_event_blocks

// File: hw/gev_regs.vh
// Register map constants for the general event register blocks.
`ifndef GEV_REGS_VH
`define GEV_REGS_VH
// Default block bases in system I/O space; each block starts on a 32-bit boundary.
`define GEV_BANK0_BASE 16'h0040
`define GEV_BANK1_BASE 16'h0048
// Block length in bytes; flags take the first half and the mask the second half.
`define GEV_BLOCK_LEN 16'h0002
// Lid control byte and its fields.
`define GEV_LID_CTRL_ADDR 16'h0200
`define GEV_LID_POLARITY_BIT 0
`define GEV_LID_FLAG_BIT 1
// Query port of the embedded controller event source.
`define GEV_QUERY_ADDR 16'h0062
`define GEV_QUERY_AC 8'h22
`define GEV_QUERY_DOCK 8'h23
// Bank 0 bit positions used by on-chip event sources.
`define GEV_EC_BIT 0
`define GEV_LID_BIT 1
`define GEV_RING_BIT 2
// Reset values.
`define GEV_FLAGS_RESET 8'h00
`define GEV_MASK_RESET 8'h00
`define GEV_LID_POLARITY_RESET 1'b0
// Input synchroniser depth.
`define GEV_SYNC_DEPTH 3
// Edges after reset until every synchronised pin shows its real level.
`define GEV_SYNC_WARM 3'h4
`endif

// File: tb/gev_platform.sv
// Behavioural model of the platform event sources wired to the event pins.
`timescale 1ns/1ps
module gev_platform (
    input wire clk_in,
    output reg [7:0] bank0_event_out,
    output reg [7:0] bank1_event_out,
    output reg lid_out,
    output reg ring_n_out,
    output reg mains_detect_n_out,
    output reg dock_event_out
);
    // Pins rest inactive; a floating pin here would set flags by itself.
    initial begin
        bank0_event_out = 8'h00;
        bank1_event_out = 8'h00;
        lid_out = 1'b1;
        ring_n_out = 1'b1;
        mains_detect_n_out = 1'b1;
        dock_event_out = 1'b0;
    end
    // Pins change just after a falling edge, clear of the sampling edge.
    task set_pins(input [7:0] b0, input [7:0] b1, input l, input rn, input acn, input dk);
        begin
            @(negedge clk_in);
            bank0_event_out = b0;
            bank1_event_out = b1;
            lid_out = l;
            ring_n_out = rn;
            mains_detect_n_out = acn;
            dock_event_out = dk;
        end
    endtask
endmodule // gev_platform

// File: tb/gev_event_blocks_asserts.sv
// Port-level checker for the general event register blocks.
`timescale 1ns/1ps
module gev_checker (
    input wire clk_in,
    input wire arst_n_in,
    input wire [15:0] io_addr_in,
    input wire io_rd_in,
    input wire io_wr_in,
    input wire [7:0] io_wdata_in,
    input wire [7:0] io_rdata_out,
    input wire io_rvalid_out,
    input wire [7:0] bank0_event_in,
    input wire sleeping_in,
    input wire system_control_interrupt_out,
    input wire wake_request_out
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);
    // Both masks cleared two cycles apart, as the bench's write task spaces them.
    sequence s_masks_off;
        io_wr_in && io_addr_in == 16'h0041 && io_wdata_in == 8'h00 ##2
        io_wr_in && io_addr_in == 16'h0049 && io_wdata_in == 8'h00;
    endsequence
    sequence s_mask0_on;
        io_wr_in && io_addr_in == 16'h0041 && io_wdata_in[0];
    endsequence
    a_read_answer: assert property (io_rd_in |=> io_rvalid_out)
        else $error("read not answered next cycle");
    a_read_idle: assert property (!io_rd_in |=> !io_rvalid_out && io_rdata_out == 8'h00)
        else $error("read data without a read");
    a_reset_quiet: assert property ($rose(arst_n_in) |-> !system_control_interrupt_out)
        else $error("interrupt high after reset");
    a_irq_raise: assert property (bank0_event_in[0] [*6] ##0 s_mask0_on
        |-> ##[1:3] system_control_interrupt_out)
        else $error("enabled flag gave no interrupt");
    a_irq_off: assert property (s_masks_off |=> ##1 !system_control_interrupt_out)
        else $error("interrupt with all masks clear");
    a_wake_clears: assert property ($fell(sleeping_in) |-> ##[1:6] !wake_request_out)
        else $error("wake kept after sleep ended");
    a_wake_hold: assert property (sleeping_in [*5] ##0 wake_request_out |=> wake_request_out)
        else $error("wake dropped while asleep");
    a_wake_awake: assert property (!sleeping_in [*6] |-> !wake_request_out)
        else $error("wake raised while awake");
endmodule // gev_checker
bind gev_event_blocks gev_checker u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .io_addr_in(io_addr_in), .io_rd_in(io_rd_in), .io_wr_in(io_wr_in),
    .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out), .io_rvalid_out(io_rvalid_out),
    .bank0_event_in(bank0_event_in), .sleeping_in(sleeping_in),
    .system_control_interrupt_out(system_control_interrupt_out),
    .wake_request_out(wake_request_out));

// File: tb/gev_event_blocks_tb.sv
// Self-checking testbench for the general event register blocks.
`timescale 1ns/1ps
module gev_event_blocks_tb;
    reg clk_in = 1'b0;
    reg arst_n_in = 1'b0;
    reg [15:0] io_addr_in = 16'h0000;
    reg io_rd_in = 1'b0;
    reg io_wr_in = 1'b0;
    reg [7:0] io_wdata_in = 8'h00;
    reg sleeping_in = 1'b0;
    wire [7:0] io_rdata_out, b0, b1;
    wire io_rvalid_out, lid, rn, acn, dk, irq, wake;
    integer miscompares = 0;
    integer comparisons = 0;
    always #20 clk_in = ~clk_in;
    gev_platform src (.clk_in(clk_in), .bank0_event_out(b0), .bank1_event_out(b1),
        .lid_out(lid), .ring_n_out(rn), .mains_detect_n_out(acn), .dock_event_out(dk));
    gev_event_blocks dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .io_addr_in(io_addr_in),
        .io_rd_in(io_rd_in), .io_wr_in(io_wr_in), .io_wdata_in(io_wdata_in),
        .io_rdata_out(io_rdata_out), .io_rvalid_out(io_rvalid_out), .bank0_event_in(b0),
        .bank1_event_in(b1), .lid_in(lid), .ring_n_in(rn), .mains_detect_n_in(acn),
        .dock_event_in(dk), .sleeping_in(sleeping_in), .system_control_interrupt_out(irq),
        .wake_request_out(wake));
    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task cmp8(input [7:0] g, input [7:0] e);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("ERROR t=%0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    // Strobes last one cycle, so back-to-back calls leave one idle cycle.
    task wr(input [15:0] a, input [7:0] d);
        begin
            @(negedge clk_in);
            io_addr_in = a;
            io_wdata_in = d;
            io_wr_in = 1'b1;
            @(negedge clk_in);
            io_wr_in = 1'b0;
        end
    endtask
    task rdchk(input [15:0] a, input [7:0] e);
        begin
            @(negedge clk_in);
            io_addr_in = a;
            io_rd_in = 1'b1;
            @(negedge clk_in);
            io_rd_in = 1'b0;
            cmp8({7'h00, io_rvalid_out}, 8'h01);
            cmp8(io_rdata_out, e);
        end
    endtask
    // Pins pass a synchroniser, so allow six cycles before looking.
    task settle;
        repeat (6) @(negedge clk_in);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_map;
        begin
            rdchk(16'h0040, 8'h00);
            rdchk(16'h0049, 8'h00);
            rdchk(16'h0200, 8'h00);
            wr(16'h0044, 8'hff);
            rdchk(16'h0044, 8'h00);
            wr(16'h0041, 8'ha5);
            wr(16'h0049, 8'h5a);
            rdchk(16'h0041, 8'ha5);
            rdchk(16'h0049, 8'h5a);
            wr(16'h0041, 8'h00);
            wr(16'h0049, 8'h00);
        end
    endtask
    task t_flag;
        begin
            src.set_pins(8'h01, 8'h28, 1'b1, 1'b1, 1'b1, 1'b0);
            settle;
            cmp8({7'h00, irq}, 8'h00);
            wr(16'h0041, 8'h01);
            @(negedge clk_in);
            cmp8({7'h00, irq}, 8'h01);
            wr(16'h0041, 8'h00);
            @(negedge clk_in);
            cmp8({7'h00, irq}, 8'h00);
            wr(16'h0048, 8'h08);
            rdchk(16'h0048, 8'h28);
            wr(16'h0049, 8'h20);
            @(negedge clk_in);
            cmp8({7'h00, irq}, 8'h01);
            wr(16'h0041, 8'h01);
            src.set_pins(8'h00, 8'h00, 1'b1, 1'b1, 1'b1, 1'b0);
            settle;
            wr(16'h0048, 8'h00);
            rdchk(16'h0048, 8'h28);
            wr(16'h0048, 8'h28);
            wr(16'h0040, 8'hff);
            @(negedge clk_in);
            cmp8({7'h00, irq}, 8'h00);
            rdchk(16'h0048, 8'h00);
            wr(16'h0041, 8'h00);
            wr(16'h0049, 8'h00);
        end
    endtask
    task t_lid;
        begin
            src.set_pins(8'h00, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0);
            settle;
            rdchk(16'h0200, 8'h02);
            rdchk(16'h0040, 8'h02);
            wr(16'h0200, 8'h03);
            wr(16'h0040, 8'h02);
            rdchk(16'h0200, 8'h01);
            src.set_pins(8'h00, 8'h00, 1'b1, 1'b1, 1'b1, 1'b0);
            settle;
            rdchk(16'h0200, 8'h03);
            wr(16'h0200, 8'h02);
            wr(16'h0040, 8'h02);
        end
    endtask
    task t_query;
        begin
            src.set_pins(8'h00, 8'h00, 1'b1, 1'b1, 1'b0, 1'b1);
            settle;
            rdchk(16'h0040, 8'h01);
            rdchk(16'h0062, 8'h22);
            rdchk(16'h0062, 8'h23);
            rdchk(16'h0062, 8'h00);
            src.set_pins(8'h00, 8'h00, 1'b1, 1'b0, 1'b1, 1'b0);
            settle;
            wr(16'h0040, 8'h01);
            rdchk(16'h0040, 8'h04);
        end
    endtask
    task t_wake;
        begin
            @(negedge clk_in);
            sleeping_in = 1'b1;
            wr(16'h0049, 8'h04);
            src.set_pins(8'h00, 8'h04, 1'b1, 1'b1, 1'b1, 1'b0);
            settle;
            cmp8({7'h00, wake}, 8'h01);
            sleeping_in = 1'b0;
            settle;
            cmp8({7'h00, wake}, 8'h00);
            wr(16'h0049, 8'h00);
            @(negedge clk_in);
            cmp8({7'h00, irq}, 8'h00);
        end
    endtask
    task conclude;
        begin
            $display("comparisons %0d miscompares %0d", comparisons, miscompares);
            if (miscompares == 0 && comparisons > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (3) @(negedge clk_in);
        arst_n_in = 1'b1;
        t_map;
        t_flag;
        t_lid;
        t_query;
        t_wake;
        conclude;
    end
    // The scenarios need well under a thousand cycles.
    initial begin
        #160000;
        miscompares = miscompares + 1;
        conclude;
    end
endmodule // gev_event_blocks_tb
